// ### hw/fac_map.svh
// Command codes, addresses and bus timing for the auxiliary-mode flash host
// Summary of operation
// - In lock-register mode A0 enters program entry and the next write programs the lock register.
// - Lock-register exit is 90 then 00 at any address, and a 03 word count in the exit state also returns to read.
// - From the first unlock state, 55 at 2AA reaches the second, F0 returns to read, and 70 gives a status read.
// - In the second unlock state A0 at 555 programs a word, 25 at a sector loads the buffer, 90 at 555 exits, F0 backs out.
`ifndef FAC_MAP_SVH
`define FAC_MAP_SVH

`define FAC_ADDR_UNLOCK1 24'h000555
`define FAC_ADDR_UNLOCK2 24'h0002aa
`define FAC_D_RESET      16'h00f0
`define FAC_D_STAT_RD    16'h0070
`define FAC_D_STAT_CLR   16'h0071
`define FAC_D_UNLOCK1    16'h00aa
`define FAC_D_UNLOCK2    16'h0055
`define FAC_D_PROG       16'h00a0
`define FAC_D_BUF_LOAD   16'h0025
`define FAC_D_EXIT_ENTRY 16'h0090
`define FAC_D_EXIT       16'h0000
`define FAC_D_WORD_CNT   16'h0003

`define FAC_CLK_NS       25
`define FAC_T_SETUP_NS   25
`define FAC_T_PULSE_NS   50
`define FAC_T_HOLD_NS    25
`define FAC_CYC(ns)      (((ns) + `FAC_CLK_NS - 1) / `FAC_CLK_NS)
`define FAC_SETUP_CYC    `FAC_CYC(`FAC_T_SETUP_NS)
`define FAC_PULSE_CYC    `FAC_CYC(`FAC_T_PULSE_NS)
`define FAC_HOLD_CYC     `FAC_CYC(`FAC_T_HOLD_NS)
`define FAC_SYNC_CYC     8'h02

`endif

// ### hw/fac_pkg.sv
// Types shared by the auxiliary-mode flash host
package fac_pkg;
  localparam int FAC_AW = 24;
  localparam int FAC_DW = 16;

  typedef enum logic [3:0] {
    FAC_OP_READ     = 4'h0,
    FAC_OP_RESET    = 4'h1,
    FAC_OP_STAT_RD  = 4'h2,
    FAC_OP_STAT_CLR = 4'h3,
    FAC_OP_LOCK_PG  = 4'h4,
    FAC_OP_LOCK_EXT = 4'h5,
    FAC_OP_LOCK_WC  = 4'h6,
    FAC_OP_SS_UNLK  = 4'h7,
    FAC_OP_SS_PROG  = 4'h8,
    FAC_OP_SS_BUF   = 4'h9,
    FAC_OP_SS_EXIT  = 4'ha,
    FAC_OP_RAW      = 4'hb
  } fac_op_e;

  typedef enum logic [6:0] {
    FAC_M_READ   = 7'h01,
    FAC_M_LOCK   = 7'h02,
    FAC_M_QUERY  = 7'h04,
    FAC_M_SECURE = 7'h08,
    FAC_M_UL1    = 7'h10,
    FAC_M_UL2    = 7'h20,
    FAC_M_BUFFER = 7'h40
  } fac_mode_e;

  typedef enum logic [3:0] {
    FAC_B_IDLE = 4'h1, FAC_B_SETUP = 4'h2, FAC_B_PULSE = 4'h4, FAC_B_HOLD = 4'h8
  } fac_bst_e;

  typedef enum logic [3:0] {
    FAC_S_IDLE = 4'h1, FAC_S_ISSUE = 4'h2, FAC_S_WAIT = 4'h4, FAC_S_DONE = 4'h8
  } fac_st_e;

  typedef struct packed {
    fac_op_e            op;
    fac_mode_e          mode;
    logic [FAC_AW-1:0]  addr;
    logic [FAC_DW-1:0]  data;
  } fac_cmd_s;

  typedef struct packed {
    logic               wr;
    logic [FAC_AW-1:0]  addr;
    logic [FAC_DW-1:0]  data;
  } fac_req_s;

  typedef struct packed {
    logic               ce_n;
    logic               we_n;
    logic               oe_n;
    logic               dq_oe_n;
    logic [FAC_AW-1:0]  addr;
    logic [FAC_DW-1:0]  dq_o;
  } fac_pins_s;

  typedef struct packed {
    fac_bst_e               st;
    logic [7:0]             cnt;
    logic                   wr;
    fac_pins_s              pins;
    logic [2:0][FAC_DW-1:0] sync;
    logic [FAC_DW-1:0]      rdata;
    logic                   done;
  } fac_bus_state_s;

  typedef struct packed {
    fac_st_e                st;
    fac_mode_e              mode;
    fac_mode_e              mode_after;
    logic [1:0]             step;
    logic [1:0]             nwr;
    logic                   rd;
    logic [2:0][FAC_AW-1:0] a;
    logic [2:0][FAC_DW-1:0] d;
    logic                   rsp_valid;
    logic                   rsp_err;
    logic [FAC_DW-1:0]      rsp_data;
  } fac_state_s;
endpackage : fac_pkg

// ### hw/fac_bus_cycle.sv
// Single flash bus cycle engine: one write or read with pin timing
`timescale 1ns/1ps
`default_nettype none
`include "fac_map.svh"
module fac_bus_cycle import fac_pkg::*; #(
  parameter logic [7:0] SETUP_CYC = 8'(`FAC_SETUP_CYC),
  parameter logic [7:0] PULSE_CYC = 8'(`FAC_PULSE_CYC),
  parameter logic [7:0] HOLD_CYC  = 8'(`FAC_HOLD_CYC)
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              req_valid,
  input  wire fac_req_s          req,
  output logic                   req_ready,
  output logic                   done,
  output logic [FAC_DW-1:0]      rdata,
  output fac_pins_s              pins,
  input  wire logic [FAC_DW-1:0] dq_i
);
  fac_bus_state_s st_ff, nxt_st;

  // Cycle sequencing and read sampling
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.done    = 1'b0;
    nxt_st.sync[0] = dq_i;
    nxt_st.sync[1] = st_ff.sync[0];
    nxt_st.sync[2] = st_ff.sync[1];
    case (st_ff.st)
      FAC_B_IDLE: begin
        if (req_valid) begin
          nxt_st.st           = FAC_B_SETUP;
          nxt_st.cnt          = SETUP_CYC;
          nxt_st.wr           = req.wr;
          nxt_st.pins.ce_n    = 1'b0;
          nxt_st.pins.addr    = req.addr;
          nxt_st.pins.dq_o    = req.data;
          nxt_st.pins.dq_oe_n = ~req.wr; // Drive data only on writes
        end
      end
      FAC_B_SETUP: begin
        nxt_st.cnt = st_ff.cnt - 8'h01;
        if (st_ff.cnt <= 8'h01) begin
          nxt_st.st        = FAC_B_PULSE;
          // Reads stay longer so stages 2 and 3 hold only strobed data
          nxt_st.cnt       = st_ff.wr ? PULSE_CYC : PULSE_CYC + `FAC_SYNC_CYC;
          nxt_st.pins.we_n = ~st_ff.wr;
          nxt_st.pins.oe_n = st_ff.wr;
        end
      end
      FAC_B_PULSE: begin
        if (st_ff.cnt > 8'h01) begin
          nxt_st.cnt = st_ff.cnt - 8'h01;
        end else if (st_ff.wr || (st_ff.sync[1] == st_ff.sync[2])) begin
          nxt_st.rdata     = st_ff.wr ? st_ff.rdata : st_ff.sync[2];
          nxt_st.st        = FAC_B_HOLD;
          nxt_st.cnt       = HOLD_CYC;
          nxt_st.pins.we_n = 1'b1; // Rising edge latches the command
          nxt_st.pins.oe_n = 1'b1;
        end
      end
      FAC_B_HOLD: begin
        nxt_st.cnt = st_ff.cnt - 8'h01;
        if (st_ff.cnt <= 8'h01) begin
          nxt_st.st           = FAC_B_IDLE;
          nxt_st.pins.ce_n    = 1'b1;
          nxt_st.pins.dq_oe_n = 1'b1;
          nxt_st.done         = 1'b1;
        end
      end
      default: nxt_st.st = FAC_B_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff      <= '0;
      st_ff.st   <= FAC_B_IDLE;
      st_ff.pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_oe_n: 1'b1,
                      addr: '0, dq_o: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign req_ready = (st_ff.st == FAC_B_IDLE);
  assign done      = st_ff.done;
  assign rdata     = st_ff.rdata;
  assign pins      = st_ff.pins;
endmodule : fac_bus_cycle
`default_nettype wire

// ### hw/fac_host.sv
// Host controller issuing auxiliary-mode command sequences to a parallel flash
`timescale 1ns/1ps
`default_nettype none
`include "fac_map.svh"
module fac_host import fac_pkg::*; #(
  parameter logic [7:0] SETUP_CYC = 8'(`FAC_SETUP_CYC),
  parameter logic [7:0] PULSE_CYC = 8'(`FAC_PULSE_CYC),
  parameter logic [7:0] HOLD_CYC  = 8'(`FAC_HOLD_CYC)
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              cmd_valid,
  input  wire fac_cmd_s          cmd,
  output logic                   cmd_ready,
  output logic                   rsp_valid,
  output logic                   rsp_err,
  output logic [FAC_DW-1:0]      rsp_data,
  output fac_mode_e              mode_mirror,
  output logic                   flash_ce_n,
  output logic                   flash_we_n,
  output logic                   flash_oe_n,
  output logic [FAC_AW-1:0]      flash_addr,
  output logic [FAC_DW-1:0]      flash_dq_o,
  output logic                   flash_dq_oe_n,
  input  wire logic [FAC_DW-1:0] flash_dq_i
);
  fac_state_s        st_ff, nxt_st;
  logic              bus_valid;
  fac_req_s          bus_req;
  logic              bus_ready;
  logic              bus_done;
  logic [FAC_DW-1:0] bus_rdata;
  fac_pins_s         pins;

  // Whether an operation has a defined transition in the current mode
  function automatic logic op_legal(input fac_op_e op, input fac_mode_e m);
    case (op)
      FAC_OP_READ, FAC_OP_RAW: op_legal = 1'b1;
      FAC_OP_RESET:    op_legal = (m != FAC_M_BUFFER) && (m != FAC_M_READ);
      FAC_OP_STAT_RD:  op_legal = m inside {FAC_M_LOCK, FAC_M_QUERY, FAC_M_SECURE,
                                            FAC_M_UL1};
      FAC_OP_STAT_CLR: op_legal = m inside {FAC_M_LOCK, FAC_M_QUERY, FAC_M_SECURE};
      FAC_OP_LOCK_PG, FAC_OP_LOCK_EXT, FAC_OP_LOCK_WC:
        op_legal = (m == FAC_M_LOCK);
      FAC_OP_SS_UNLK:  op_legal = (m == FAC_M_SECURE);
      FAC_OP_SS_PROG, FAC_OP_SS_BUF, FAC_OP_SS_EXIT:
        op_legal = (m == FAC_M_UL2);
      default:         op_legal = 1'b0;
    endcase
  endfunction : op_legal

  // Mode the device is left in once an operation completes
  function automatic fac_mode_e op_mode(input fac_cmd_s c, input fac_mode_e m);
    case (c.op)
      FAC_OP_RESET:    op_mode = (m == FAC_M_UL2) ? FAC_M_SECURE : FAC_M_READ;
      FAC_OP_STAT_RD:  op_mode = (m == FAC_M_UL1) ? FAC_M_SECURE : m;
      FAC_OP_LOCK_PG:  op_mode = FAC_M_LOCK;
      FAC_OP_LOCK_EXT: op_mode = FAC_M_READ;
      FAC_OP_LOCK_WC:  op_mode = FAC_M_READ;
      FAC_OP_SS_UNLK:  op_mode = FAC_M_UL2;
      FAC_OP_SS_PROG:  op_mode = FAC_M_SECURE;
      FAC_OP_SS_BUF:   op_mode = FAC_M_BUFFER;
      FAC_OP_SS_EXIT:  op_mode = FAC_M_READ;
      FAC_OP_RAW:      op_mode = c.mode;
      default:         op_mode = m;
    endcase
  endfunction : op_mode

  // Command acceptance, sequence expansion and cycle stepping
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.rsp_valid = 1'b0;
    case (st_ff.st)
      FAC_S_IDLE: begin
        if (cmd_valid) begin
          nxt_st.step       = 2'd0;
          nxt_st.rd         = 1'b0;
          nxt_st.nwr        = 2'd1;
          nxt_st.a          = {3{cmd.addr}};
          nxt_st.d          = {3{cmd.data}};
          nxt_st.mode_after = op_mode(cmd, st_ff.mode);
          nxt_st.st         = FAC_S_ISSUE;
          case (cmd.op)
            FAC_OP_READ: begin
              nxt_st.nwr = 2'd0;
              nxt_st.rd  = 1'b1;
            end
            FAC_OP_RESET: begin
              nxt_st.d[0] = `FAC_D_RESET;
            end
            FAC_OP_STAT_RD: begin
              nxt_st.a[0] = `FAC_ADDR_UNLOCK1;
              nxt_st.d[0] = `FAC_D_STAT_RD;
              nxt_st.rd   = 1'b1;
            end
            FAC_OP_STAT_CLR: begin
              nxt_st.a[0] = `FAC_ADDR_UNLOCK1;
              nxt_st.d[0] = `FAC_D_STAT_CLR;
            end
            FAC_OP_LOCK_PG: begin
              nxt_st.nwr  = 2'd2;
              nxt_st.d[0] = `FAC_D_PROG;
            end
            FAC_OP_LOCK_EXT, FAC_OP_LOCK_WC: begin
              nxt_st.nwr  = 2'd2;
              nxt_st.d[0] = `FAC_D_EXIT_ENTRY;
              nxt_st.d[1] = (cmd.op == FAC_OP_LOCK_WC) ? `FAC_D_WORD_CNT : `FAC_D_EXIT;
            end
            FAC_OP_SS_UNLK: begin
              // Full unlock pair always, so a set abort flag never diverts
              nxt_st.nwr  = 2'd2;
              nxt_st.a[0] = `FAC_ADDR_UNLOCK1;
              nxt_st.d[0] = `FAC_D_UNLOCK1;
              nxt_st.a[1] = `FAC_ADDR_UNLOCK2;
              nxt_st.d[1] = `FAC_D_UNLOCK2;
            end
            FAC_OP_SS_PROG: begin
              nxt_st.nwr  = 2'd2;
              nxt_st.a[0] = `FAC_ADDR_UNLOCK1;
              nxt_st.d[0] = `FAC_D_PROG;
            end
            FAC_OP_SS_BUF: begin
              nxt_st.d[0] = `FAC_D_BUF_LOAD;
            end
            FAC_OP_SS_EXIT: begin
              nxt_st.nwr  = 2'd2;
              nxt_st.a[0] = `FAC_ADDR_UNLOCK1;
              nxt_st.d[0] = `FAC_D_EXIT_ENTRY;
              nxt_st.d[1] = `FAC_D_EXIT;
            end
            default: ;
          endcase
          // Unmatched operations emit no cycle at all
          if (!op_legal(cmd.op, st_ff.mode)) begin
            nxt_st.st        = FAC_S_IDLE;
            nxt_st.rsp_valid = 1'b1;
            nxt_st.rsp_err   = 1'b1;
          end
        end
      end
      FAC_S_ISSUE: begin
        if (bus_ready) begin
          nxt_st.st = FAC_S_WAIT;
        end
      end
      FAC_S_WAIT: begin
        if (bus_done) begin
          if ({1'b0, st_ff.step} + 3'd1 < {1'b0, st_ff.nwr} + {2'b00, st_ff.rd}) begin
            nxt_st.step = st_ff.step + 2'd1;
            nxt_st.st   = FAC_S_ISSUE;
          end else begin
            nxt_st.st = FAC_S_DONE;
          end
        end
      end
      FAC_S_DONE: begin
        nxt_st.st        = FAC_S_IDLE;
        nxt_st.mode      = st_ff.mode_after;
        nxt_st.rsp_valid = 1'b1;
        nxt_st.rsp_err   = 1'b0;
        nxt_st.rsp_data  = st_ff.rd ? bus_rdata : st_ff.rsp_data;
      end
      default: nxt_st.st = FAC_S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_ff            <= '0;
      st_ff.st         <= FAC_S_IDLE;
      st_ff.mode       <= FAC_M_READ;
      st_ff.mode_after <= FAC_M_READ;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Bus request for the current step; the last step is the read if any
  always_comb begin
    bus_valid    = (st_ff.st == FAC_S_ISSUE);
    bus_req.wr   = (st_ff.step < st_ff.nwr);
    bus_req.addr = st_ff.a[st_ff.step];
    bus_req.data = st_ff.d[st_ff.step];
  end

  fac_bus_cycle #(
    .SETUP_CYC (SETUP_CYC),
    .PULSE_CYC (PULSE_CYC),
    .HOLD_CYC  (HOLD_CYC)
  ) u_bus (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .req_valid (bus_valid),
    .req       (bus_req),
    .req_ready (bus_ready),
    .done      (bus_done),
    .rdata     (bus_rdata),
    .pins      (pins),
    .dq_i      (flash_dq_i)
  );

  // Outputs
  assign cmd_ready     = (st_ff.st == FAC_S_IDLE);
  assign rsp_valid     = st_ff.rsp_valid;
  assign rsp_err       = st_ff.rsp_err;
  assign rsp_data      = st_ff.rsp_data;
  assign mode_mirror   = st_ff.mode;
  assign flash_ce_n    = pins.ce_n;
  assign flash_we_n    = pins.we_n;
  assign flash_oe_n    = pins.oe_n;
  assign flash_addr    = pins.addr;
  assign flash_dq_o    = pins.dq_o;
  assign flash_dq_oe_n = pins.dq_oe_n;
endmodule : fac_host
`default_nettype wire

// ### dv/fac_host_properties.sv
// Bus and mode-tracking properties of the flash host
`timescale 1ns/1ps
`default_nettype none
module fac_host_chk import fac_pkg::*; #(
  parameter logic [7:0] SETUP_CYC = 8'h01,
  parameter logic [7:0] PULSE_CYC = 8'h02,
  parameter logic [7:0] HOLD_CYC  = 8'h01
) (
  input wire logic      clk_sys,
  input wire logic      rst,
  input wire logic      cmd_valid,
  input wire fac_cmd_s  cmd,
  input wire logic      cmd_ready,
  input wire logic      rsp_valid,
  input wire logic      rsp_err,
  input wire fac_mode_e mode_mirror,
  input wire logic      flash_ce_n,
  input wire logic      flash_we_n,
  input wire logic      flash_oe_n,
  input wire logic      flash_dq_oe_n
);
  logic       tk;
  logic [7:0] wl_ff;
  // Accepted command
  assign tk = cmd_valid && cmd_ready;
  // Cycles the write strobe has been low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) wl_ff <= 8'h00;
    else wl_ff <= flash_we_n ? 8'h00 : wl_ff + 8'h01;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_we_width: assert property ($rose(flash_we_n) |-> wl_ff == PULSE_CYC)
    else $error("write strobe width wrong");
  chk_write_drive: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && !flash_dq_oe_n)
    else $error("write strobe without selected driven bus");
  chk_read_release: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n && flash_dq_oe_n)
    else $error("read strobe with bus driven");
  chk_refuse_quiet: assert property (tk && cmd.op == FAC_OP_SS_BUF && mode_mirror != FAC_M_UL2
    |=> rsp_valid && rsp_err && flash_ce_n)
    else $error("refused command not answered at once");
  chk_reset_read: assert property (tk && cmd.op == FAC_OP_RESET && mode_mirror inside
    {FAC_M_LOCK, FAC_M_QUERY, FAC_M_SECURE, FAC_M_UL1}
    |-> ##[1:60] rsp_valid && mode_mirror == FAC_M_READ)
    else $error("reset did not return to read");
  chk_ul2_back: assert property (tk && cmd.op == FAC_OP_RESET && mode_mirror == FAC_M_UL2
    |-> ##[1:60] rsp_valid && mode_mirror == FAC_M_SECURE)
    else $error("reset in second unlock not back to secure");
  chk_unlock_pair: assert property (tk && cmd.op == FAC_OP_SS_UNLK && mode_mirror == FAC_M_SECURE
    |-> ##[1:60] rsp_valid && mode_mirror == FAC_M_UL2)
    else $error("unlock did not reach second unlock");
  chk_exit_read: assert property (tk && cmd.op == FAC_OP_SS_EXIT && mode_mirror == FAC_M_UL2
    |-> ##[1:60] rsp_valid && mode_mirror == FAC_M_READ)
    else $error("exit did not return to read");
  chk_stat_stay: assert property (tk && cmd.op == FAC_OP_STAT_RD && mode_mirror == FAC_M_QUERY
    |-> ##[1:60] rsp_valid && mode_mirror == FAC_M_QUERY)
    else $error("status read left query mode");
  chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  chk_mirror_quiet: assert property ($changed(mode_mirror) |-> rsp_valid)
    else $error("mode changed without response");
  cover property (tk && cmd.op == FAC_OP_SS_UNLK);
  cover property (rsp_valid && rsp_err);
  cover property (rsp_valid && mode_mirror == FAC_M_BUFFER);
endmodule : fac_host_chk
bind fac_host fac_host_chk #(.SETUP_CYC(SETUP_CYC), .PULSE_CYC(PULSE_CYC),
  .HOLD_CYC(HOLD_CYC)) i_chk (.*);
`default_nettype wire

// ### dv/fac_flash_model.sv
// Behavioural flash device: lock, query and secure-sector command states
`timescale 1ns/1ps
`default_nettype none
module fac_flash_model import fac_pkg::*; #(
  parameter logic [15:0] LOCK_INIT = 16'hffff, // Arbitrary power-up words
  parameter logic [15:0] SEC_INIT  = 16'h1234,
  parameter logic [7:0]  ENT_LOCK  = 8'h40,    // Arbitrary mode entry codes
  parameter logic [7:0]  ENT_QRY   = 8'h98,
  parameter logic [7:0]  ENT_SEC   = 8'h88
) (
  input  wire logic              ce_n,
  input  wire logic              we_n,
  input  wire logic              oe_n,
  input  wire logic [FAC_AW-1:0] addr,
  input  wire logic [FAC_DW-1:0] dq_o,
  output logic [FAC_DW-1:0]      dq_i
);
  typedef enum logic [3:0] {
    S_RD, S_LOCK, S_LPG, S_LEXT, S_QRY, S_SEC, S_UL1, S_UL2, S_WPG, S_BUF, S_SEXT, S_SPG
  } fac_fm_st_e;
  fac_fm_st_e  st = S_RD;
  logic        sr_set = 1'b0, sr_clr = 1'b0, sr;
  logic [7:0]  stat = 8'h81;
  logic [15:0] lk = LOCK_INIT, sec = SEC_INIT, last = 16'h0000, rv;
  logic        a5, a2;
  logic [7:0]  d;
  // Address and data decode
  assign a5 = addr == 24'h000555;
  assign a2 = addr == 24'h0002aa;
  assign d  = dq_o[7:0];
  // Status-read flag: set by writes, cleared by reads, one driver each
  assign sr = sr_set ^ sr_clr;
  // Command decode at the end of each write; others leave state alone, except in the unlock states with stat[3] set, which go to S_SPG
  always @(posedge we_n) begin
    if (!ce_n) begin
      case (st)
        S_RD: st <= d == ENT_LOCK ? S_LOCK : d == ENT_QRY ? S_QRY : d == ENT_SEC ? S_SEC : S_RD;
        S_LOCK, S_QRY, S_SEC: begin
          if (d == 8'hf0) st <= S_RD;
          else if (a5 && d == 8'h70) sr_set <= ~sr_clr;
          else if (a5 && d == 8'h71) stat <= 8'h80;
          else if (st == S_LOCK && d == 8'h90) st <= S_LEXT;
          else if (st == S_LOCK && d == 8'ha0) st <= S_LPG;
          else if (st == S_SEC && a5 && d == 8'haa) st <= S_UL1;
        end
        S_LPG: begin
          lk <= dq_o;
          st <= S_LOCK;
        end
        S_LEXT: if (d == 8'h00 || d == 8'h03) st <= S_RD;
        S_UL1: begin
          if (a2 && d == 8'h55) st <= S_UL2;
          else if (d == 8'hf0) st <= S_RD;
          else if (a5 && d == 8'h70) begin
            sr_set <= ~sr_clr;
            st <= S_SEC;
          end
          else if (stat[3]) st <= S_SPG;
        end
        S_UL2: begin
          if (d == 8'hf0) st <= S_SEC;
          else if (a5 && d == 8'ha0) st <= S_WPG;
          else if (d == 8'h25) st <= S_BUF;
          else if (a5 && d == 8'h90) st <= S_SEXT;
          else if (stat[3]) st <= S_SPG;
        end
        S_WPG: begin
          sec <= dq_o;
          st  <= S_SEC;
        end
        S_BUF: begin // Load not confirmed: abort flag set
          stat[3] <= d != 8'h29;
          st      <= S_SEC;
        end
        S_SEXT: if (d == 8'h00) st <= S_RD;
        default: st <= S_SEC; // Programming completes at once
      endcase
    end
  end
  // Read word by state; a released bus shows the inverse of the last word
  always_comb begin
    if (sr) rv = {8'h00, stat};
    else if (st == S_LOCK) rv = lk;
    else if (st == S_QRY) rv = {8'h0c, addr[7:0]};
    else if (st == S_SEC) rv = sec;
    else rv = {8'h0a, addr[7:0]};
    dq_i = (ce_n || oe_n) ? ~last : rv;
  end
  // Status shows for one read only
  always @(posedge oe_n) begin
    if (!ce_n) begin
      last <= rv;
      sr_clr <= sr_set;
    end
  end
endmodule : fac_flash_model
`default_nettype wire

// ### dv/test_fac_host.sv
// Directed tests of the flash host against the device model
`timescale 1ns/1ps
`default_nettype none
module test_fac_host import fac_pkg::*;;
  logic clk_sys = 1'b0, rst = 1'b1, cmd_valid = 1'b0;
  fac_cmd_s cmd = '0;
  logic cmd_ready, rsp_valid, rsp_err, flash_ce_n, flash_we_n, flash_oe_n, flash_dq_oe_n;
  logic [FAC_DW-1:0] rsp_data, flash_dq_o, flash_dq_i, rd;
  logic [FAC_AW-1:0] flash_addr;
  fac_mode_e mode_mirror;
  int n_fail = 0, n_tests = 0;
  // 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;
  fac_host i_dut (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err), .rsp_data(rsp_data),
    .mode_mirror(mode_mirror), .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
    .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_i(flash_dq_i));
  fac_flash_model i_mem (.ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n),
    .addr(flash_addr), .dq_o(flash_dq_o), .dq_i(flash_dq_i));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One command, held until taken, then wait for its response
  task automatic op(input fac_op_e o, input fac_mode_e m, input logic [23:0] a,
    input logic [15:0] d);
    int n;
    cmd_valid <= 1'b1;
    cmd <= '{o, m, a, d};
    do @(posedge clk_sys); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp_valid !== 1'b1 && n < 200);
    if (n >= 200) chk(16'h0000, 16'h0001);
    rd = rsp_data;
  endtask : op
  task automatic mchk(input fac_mode_e m);
    chk({9'h000, mode_mirror}, {9'h000, m});
  endtask : mchk
  task automatic rdchk(input logic [23:0] a, input logic [15:0] exp);
    op(FAC_OP_READ, FAC_M_READ, a, 16'h0000);
    chk(rd, exp);
    chk({15'h0000, rsp_err}, 16'h0000);
  endtask : rdchk
  task automatic t_lock;
    op(FAC_OP_RAW, FAC_M_LOCK, 24'h0, 16'h0040);
    rdchk(24'h10, 16'hffff);
    op(FAC_OP_LOCK_PG, FAC_M_READ, 24'h0, 16'h5a5a);
    rdchk(24'h10, 16'h5a5a);
    op(FAC_OP_RAW, FAC_M_LOCK, 24'h0, 16'h0033);
    rdchk(24'h11, 16'h5a5a);
    op(FAC_OP_RESET, FAC_M_READ, 24'h0, 16'h0000);
    mchk(FAC_M_READ);
    rdchk(24'h12, 16'h0a12);
    for (int i = 0; i < 2; i++) begin
      op(FAC_OP_RAW, FAC_M_LOCK, 24'h0, 16'h0040);
      op(i ? FAC_OP_LOCK_WC : FAC_OP_LOCK_EXT, FAC_M_READ, 24'h0, 16'h0000);
      mchk(FAC_M_READ);
      rdchk(24'h34, 16'h0a34);
    end
    $display("lock test done");
  endtask : t_lock
  task automatic t_query;
    op(FAC_OP_RAW, FAC_M_QUERY, 24'h0, 16'h0098);
    rdchk(24'h20, 16'h0c20);
    op(FAC_OP_STAT_RD, FAC_M_READ, 24'h20, 16'h0000);
    chk(rd, 16'h0081);
    mchk(FAC_M_QUERY);
    rdchk(24'h21, 16'h0c21);
    op(FAC_OP_STAT_CLR, FAC_M_READ, 24'h0, 16'h0000);
    op(FAC_OP_STAT_RD, FAC_M_READ, 24'h20, 16'h0000);
    chk(rd, 16'h0080);
    op(FAC_OP_RESET, FAC_M_READ, 24'h0, 16'h0000);
    rdchk(24'h22, 16'h0a22);
    $display("query test done");
  endtask : t_query
  task automatic t_secure;
    op(FAC_OP_RAW, FAC_M_SECURE, 24'h0, 16'h0088);
    rdchk(24'h40, 16'h1234);
    op(FAC_OP_SS_UNLK, FAC_M_READ, 24'h0, 16'h0000);
    mchk(FAC_M_UL2);
    op(FAC_OP_SS_PROG, FAC_M_READ, 24'h40, 16'hbeef);
    rdchk(24'h40, 16'hbeef);
    op(FAC_OP_SS_UNLK, FAC_M_READ, 24'h0, 16'h0000);
    op(FAC_OP_RESET, FAC_M_READ, 24'h0, 16'h0000);
    mchk(FAC_M_SECURE);
    rdchk(24'h41, 16'hbeef);
    op(FAC_OP_RAW, FAC_M_UL1, 24'h555, 16'h00aa);
    op(FAC_OP_STAT_RD, FAC_M_READ, 24'h0, 16'h0000);
    chk(rd, 16'h0080);
    mchk(FAC_M_SECURE);
    op(FAC_OP_RAW, FAC_M_UL1, 24'h555, 16'h00aa);
    op(FAC_OP_RESET, FAC_M_READ, 24'h0, 16'h0000);
    rdchk(24'h42, 16'h0a42);
    op(FAC_OP_RAW, FAC_M_SECURE, 24'h0, 16'h0088);
    op(FAC_OP_SS_UNLK, FAC_M_READ, 24'h0, 16'h0000);
    op(FAC_OP_SS_EXIT, FAC_M_READ, 24'h0, 16'h0000);
    rdchk(24'h43, 16'h0a43);
    op(FAC_OP_RAW, FAC_M_SECURE, 24'h0, 16'h0088);
    op(FAC_OP_SS_UNLK, FAC_M_READ, 24'h0, 16'h0000);
    op(FAC_OP_SS_BUF, FAC_M_READ, 24'h1000, 16'h0000);
    mchk(FAC_M_BUFFER);
    op(FAC_OP_RAW, FAC_M_SECURE, 24'h0, 16'h0000);
    rdchk(24'h44, 16'hbeef);
    op(FAC_OP_RAW, FAC_M_UL1, 24'h555, 16'h00aa);
    op(FAC_OP_RAW, FAC_M_SECURE, 24'h123, 16'h0055);
    rdchk(24'h45, 16'h0a45);
    $display("secure test done");
  endtask : t_secure
  task automatic t_refuse;
    fac_op_e ill [6] = '{FAC_OP_RESET, FAC_OP_STAT_RD, FAC_OP_STAT_CLR, FAC_OP_LOCK_PG,
      FAC_OP_SS_UNLK, FAC_OP_SS_BUF};
    op(FAC_OP_RAW, FAC_M_READ, 24'h0, 16'h00f0);
    op(FAC_OP_RAW, FAC_M_READ, 24'h0, 16'h00f0);
    for (int i = 0; i < 6; i++) begin
      op(ill[i], FAC_M_READ, 24'h0, 16'h0000);
      chk({15'h0000, rsp_err}, 16'h0001);
      mchk(FAC_M_READ);
    end
    rdchk(24'h46, 16'h0a46);
    $display("refusal test done");
  endtask : t_refuse
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_lock;
    t_query;
    t_secure;
    t_refuse;
    close_out;
  end
  // Watchdog
  initial begin
    #200000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out;
  end
endmodule : test_fac_host
`default_nettype wire
